// [logic/mac_addr_pkg.sv]
// constants and types shared by the multiplier and address datapath
// assumes one machine clock and a decoder that drives one-cycle op strobes
package mac_addr_pkg;
  localparam int DATA_W   = 16;
  localparam int PROD_W   = 32;
  localparam int AUX_N    = 8;
  localparam int PTR_W    = 3;
  localparam int SHL_ONE  = 1;
  localparam int SHL_FOUR = 4;
  localparam int SHR_SIX  = 6;
  localparam int SRC_W    = 2;
  localparam int ADJ_W    = 3;

  // product shift mode, ascending encoding
  typedef enum logic [1:0] {
    PSM_NONE  = 2'h0,
    PSM_LEFT1 = 2'h1,
    PSM_LEFT4 = 2'h2,
    PSM_RIGHT6 = 2'h3
  } shift_mode_t;

  // load source for aux registers and pointer
  typedef enum logic [1:0] {
    SRC_DATA = 2'h0,
    SRC_ACC  = 2'h1,
    SRC_PROD = 2'h2,
    SRC_IMM  = 2'h3
  } load_src_t;

  // post-update of the current aux register
  typedef enum logic [2:0] {
    ADJ_NONE = 3'h0,
    ADJ_INC  = 3'h1,
    ADJ_DEC  = 3'h2,
    ADJ_ADDX = 3'h3,
    ADJ_SUBX = 3'h4
  } adjust_t;

  // multiplier operand source for the second input
  typedef enum logic [1:0] {
    OPB_DATA  = 2'h0,
    OPB_SHORT = 2'h1,
    OPB_LONG  = 2'h2,
    OPB_PROG  = 2'h3
  } opb_src_t;

  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage

// [logic/aux_bus_if.sv]
// carries the indirect address and post-update request to the address unit
// assumes both ends share clk
`timescale 1ns/1ps
interface aux_bus_if;
  logic [15:0] curVal;
  logic [15:0] indexVal;
  logic [2:0]  adjust;
  logic [15:0] updVal;
  modport core (output indexVal, output adjust, input updVal, output curVal);
  modport unit (input indexVal, input adjust, output updVal, input curVal);
endinterface // aux_bus_if

// [logic/address_arith_unit.sv]
// address arithmetic unit: post-update value of the current aux register
// assumes the caller writes updVal back into the current register
`timescale 1ns/1ps
module address_arith_unit (
  aux_bus_if.unit ab
);
  always_comb begin
    case (mac_addr_pkg::adjust_t'(ab.adjust))
      mac_addr_pkg::ADJ_INC:  ab.updVal = ab.curVal + 16'h0001;
      mac_addr_pkg::ADJ_DEC:  ab.updVal = ab.curVal - 16'h0001;
      mac_addr_pkg::ADJ_ADDX: ab.updVal = ab.curVal + ab.indexVal;
      mac_addr_pkg::ADJ_SUBX: ab.updVal = ab.curVal - ab.indexVal;
      default:                ab.updVal = ab.curVal;
    endcase
  end
endmodule // address_arith_unit

// [logic/mult_aux_datapath.sv]
// multiplier, product shifter and aux register file of the core datapath
// assumes decoder strobes are one-cycle, synchronous to clk
`timescale 1ns/1ps

// What this block does
// - 16x16 multiply yields full 32-bit product in one cycle
// - all multiplies except unsigned one are two's-complement signed
// - 16-bit operand register and 32-bit product register hold operands, result
// - product output passes a four-mode shifter chosen by status word field
// - one mode shifts product left one bit
// - one mode shifts product left four bits for short immediates
// - one mode shifts product right six bits arithmetically
// - load-operand fills operand register; multiply takes data bus, starts
// - multiply also takes short or long immediate from instruction word
// - load-then-multiply gives one product per two cycles, long immediate slower
// - multiply-accumulate takes program and data bus operands each cycle
// - repeated MAC: PC gives coefficients, aux unit gives data addresses
// - repeat-with-clear zeroes accumulator and product before repeat begins
// - move variants copy each sample to the next higher address
// - eight aux registers chosen by a 3-bit pointer
// - aux registers and pointer load from data, acc, product or immediate
// - aux registers go to data memory or to the central arith unit
// - aux registers read and written as memory-mapped data locations
// - current aux register post-updates by one or index in same cycle
// - central arith unit may take shifted product as second input
module mult_aux_datapath (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // buses
  input  wire logic [15:0] dataBus,
  input  wire logic [15:0] progBus,
  input  wire logic [15:0] immShort,
  input  wire logic [15:0] immLong,
  input  wire logic [31:0] accIn,
  // multiplier control from decoder
  input  wire logic        loadOperandOp,
  input  wire logic        multiplyOp,
  input  wire logic        unsignedMultiplyOp,
  input  wire logic        multiplyAccumulateOp,
  input  wire logic [1:0]  opbSel,
  input  wire logic        repeatClearOp,
  input  wire logic        moveSampleEn,
  input  wire logic [1:0]  productShiftMode,
  // aux register control
  input  wire logic        auxLoad,
  input  wire logic        ptrLoad,
  input  wire logic [1:0]  auxLoadSrc,
  input  wire logic [2:0]  auxLoadSel,
  input  wire logic [15:0] auxImm,
  input  wire logic        indirectEn,
  input  wire logic [2:0]  auxAdjust,
  input  wire logic        indexLoad,
  input  wire logic [3:0]  auxMapAddr,
  input  wire logic        auxMapWrite,
  // outputs
  output logic      [15:0] operandOut,
  output logic      [31:0] productOut,
  output logic      [31:0] shiftedProduct,
  output logic      [15:0] dataAddr,
  output logic      [15:0] moveAddr,
  output logic             moveWrite,
  output logic             clearAcc,
  output logic      [15:0] auxOut,
  output logic      [15:0] auxMapData,
  output logic      [2:0]  auxPointer,
  output logic      [15:0] indexOut
);
  localparam int N = mac_addr_pkg::AUX_N;

  logic [15:0] operandReg, operandNext;
  logic [31:0] productReg, productNext;
  logic [15:0] auxRegs [N];
  logic [15:0] auxNext [N];
  logic [2:0]  auxPointerReg, auxPointerNext;
  logic [15:0] indexReg, indexNext;
  logic [15:0] dataAddrReg, dataAddrNext;
  logic        moveWriteReg, moveWriteNext;
  logic        clearAccReg, clearAccNext;
  logic [15:0] opB;
  logic [31:0] prodSigned, prodUnsigned;
  logic [15:0] loadVal;
  aux_bus_if ab ();

  address_arith_unit u_address_arith_unit (
    .ab (ab)
  );

  function automatic logic [15:0] pick_load(
    input logic [1:0]  src,
    input logic [15:0] d,
    input logic [31:0] acc,
    input logic [31:0] prod,
    input logic [15:0] imm
  );
    case (mac_addr_pkg::load_src_t'(src))
      mac_addr_pkg::SRC_DATA: pick_load = d;
      mac_addr_pkg::SRC_ACC:  pick_load = acc[15:0];
      mac_addr_pkg::SRC_PROD: pick_load = prod[15:0];
      default:                pick_load = imm;
    endcase
  endfunction

  // second multiplier operand
  always_comb begin
    case (mac_addr_pkg::opb_src_t'(opbSel))
      mac_addr_pkg::OPB_SHORT: opB = immShort;
      mac_addr_pkg::OPB_LONG:  opB = immLong;
      mac_addr_pkg::OPB_PROG:  opB = progBus;
      default:                 opB = dataBus;
    endcase
  end

  // full-width products, no truncation
  assign prodSigned = 32'($signed(operandReg) * $signed(opB));
  assign prodUnsigned = 32'(operandReg * opB);

  always_comb begin
    operandNext = operandReg;
    productNext = productReg;
    clearAccNext = 1'b0;
    if (loadOperandOp) begin
      operandNext = dataBus;
    end
    if (repeatClearOp) begin
      productNext = mac_addr_pkg::ZERO32;
      clearAccNext = 1'b1;
    end else if (unsignedMultiplyOp) begin
      productNext = prodUnsigned;
    end else if (multiplyOp) begin
      productNext = prodSigned;
    end else if (multiplyAccumulateOp) begin
      // mac: coefficient from program bus times sample from data, sample into operand
      productNext = 32'($signed(progBus) * $signed(dataBus));
      operandNext = dataBus;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      operandReg  <= mac_addr_pkg::ZERO16;
      productReg  <= mac_addr_pkg::ZERO32;
      clearAccReg <= 1'b0;
    end else begin
      operandReg  <= operandNext;
      productReg  <= productNext;
      clearAccReg <= clearAccNext;
    end
  end

  // product shifter feeding the central arith unit
  always_comb begin
    case (mac_addr_pkg::shift_mode_t'(productShiftMode))
      mac_addr_pkg::PSM_LEFT1:
        shiftedProduct = productReg << mac_addr_pkg::SHL_ONE;
      mac_addr_pkg::PSM_LEFT4:
        shiftedProduct = productReg << mac_addr_pkg::SHL_FOUR;
      mac_addr_pkg::PSM_RIGHT6:
        shiftedProduct = 32'($signed(productReg) >>>
                             mac_addr_pkg::SHR_SIX);
      default:
        shiftedProduct = productReg;
    endcase
  end

  // address unit hookup
  assign ab.curVal   = auxRegs[auxPointerReg];
  assign ab.indexVal = indexReg;
  assign ab.adjust   = indirectEn ? auxAdjust : 3'h0;
  assign loadVal = pick_load(auxLoadSrc, dataBus, accIn, productReg, auxImm);

  always_comb begin
    for (int i = 0; i < N; i++) begin
      auxNext[i] = auxRegs[i];
    end
    auxPointerNext = auxPointerReg;
    indexNext = indexReg;
    dataAddrNext = dataAddrReg;
    moveWriteNext = 1'b0;
    if (indirectEn) begin
      dataAddrNext = auxRegs[auxPointerReg];
      auxNext[auxPointerReg] = ab.updVal;
      moveWriteNext = moveSampleEn;
    end
    // explicit loads win over post-update
    if (auxLoad) begin
      auxNext[auxLoadSel] = loadVal;
    end
    if (auxMapWrite && !auxMapAddr[3]) begin
      auxNext[auxMapAddr[2:0]] = dataBus;
    end
    if (ptrLoad) begin
      auxPointerNext = loadVal[2:0];
    end
    if (indexLoad) begin
      indexNext = dataBus;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        auxRegs[i] <= mac_addr_pkg::ZERO16;
      end
      auxPointerReg <= 3'h0;
      indexReg      <= mac_addr_pkg::ZERO16;
      dataAddrReg   <= mac_addr_pkg::ZERO16;
      moveWriteReg  <= 1'b0;
    end else begin
      for (int i = 0; i < N; i++) begin
        auxRegs[i] <= auxNext[i];
      end
      auxPointerReg <= auxPointerNext;
      indexReg      <= indexNext;
      dataAddrReg   <= dataAddrNext;
      moveWriteReg  <= moveWriteNext;
    end
  end

  // outputs
  assign operandOut = operandReg;
  assign productOut = productReg;
  assign dataAddr   = dataAddrReg;
  assign moveAddr   = dataAddrReg + 16'h0001;
  assign moveWrite  = moveWriteReg;
  assign clearAcc   = clearAccReg;
  assign auxOut     = auxRegs[auxPointerReg];
  assign auxMapData = auxRegs[auxMapAddr[2:0]];
  assign auxPointer = auxPointerReg;
  assign indexOut   = indexReg;
endmodule // mult_aux_datapath

// [testbench/mult_aux_monitor.sv]
// checker on the multiplier datapath ports
// assumes one clock and a bind onto mult_aux_datapath
`timescale 1ns/1ps
module mult_aux_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // inputs
  input wire logic [15:0] dataBus,
  input wire logic        loadOperandOp,
  input wire logic        multiplyOp,
  input wire logic        unsignedMultiplyOp,
  input wire logic        multiplyAccumulateOp,
  input wire logic [1:0]  opbSel,
  input wire logic        repeatClearOp,
  input wire logic [1:0]  productShiftMode,
  // outputs
  input wire logic [15:0] operandOut,
  input wire logic [31:0] productOut,
  input wire logic [31:0] shiftedProduct,
  input wire logic        clearAcc
);
  logic signed [31:0] sProd;
  logic        [31:0] uProd;
  logic        [31:0] shExp;
  logic               plain;
  assign sProd = $signed(operandOut) * $signed(dataBus);
  assign uProd = operandOut * dataBus;
  // right shift keeps the sign so accumulated sums stay in range
  assign shExp = productShiftMode == 2'h3 ? 32'($signed(productOut) >>> 6)
    : productOut << (productShiftMode == 2'h1 ? 1 : 2 * productShiftMode);
  assign plain = !repeatClearOp && opbSel == 2'h0;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  load_operand_a: assert property (loadOperandOp |=>
    operandOut == $past(dataBus)) else $error("operand load wrong");
  operand_hold_a: assert property (
    !loadOperandOp && !multiplyAccumulateOp |=> $stable(operandOut))
    else $error("operand changed");
  signed_mult_a: assert property (
    multiplyOp && !unsignedMultiplyOp && plain |=> productOut == $past(sProd))
    else $error("signed product wrong");
  unsigned_mult_a: assert property (unsignedMultiplyOp && plain |=>
    productOut == $past(uProd)) else $error("unsigned product wrong");
  clear_product_a: assert property (repeatClearOp |=>
    productOut == 32'h0) else $error("product not cleared");
  clear_pulse_a: assert property (
    clearAcc == $past(repeatClearOp)) else $error("clear pulse wrong");
  left_shift_a: assert property (productShiftMode != 2'h3 |->
    shiftedProduct == shExp) else $error("left shift wrong");
  right_shift_a: assert property (productShiftMode == 2'h3 |->
    shiftedProduct == shExp) else $error("right shift wrong");
endmodule // mult_aux_monitor

bind mult_aux_datapath mult_aux_monitor u_mon (.*);

// [testbench/coef_rom.sv]
// coefficient table feeding the program bus
// assumes the bench steps addr like a program counter
`timescale 1ns/1ps
module coef_rom (
  // fetch
  input  wire logic [15:0] addr,
  output logic      [15:0] coef
);
  // both halves differ so a swapped byte shows
  assign coef = {addr[7:0] ^ 8'ha5, addr[7:0]};
endmodule // coef_rom

// [testbench/multiplier_and_aux_address_unit_test.sv]
// self-checking bench for the multiplier and aux address datapath
// assumes the checker binds itself from its own file
`timescale 1ns/1ps
module multiplier_and_aux_address_unit_test;
  localparam logic [9:0] LOAD_OP = 10'h200, MUL_OP = 10'h100;
  localparam logic [9:0] UMUL_OP = 10'h80, ACC_OP = 10'h40, CLR_OP = 10'h20;
  localparam logic [9:0] AUX_LD = 10'h10, PTR_LD = 10'h8, IND_OP = 10'h4;
  localparam logic [9:0] IDX_LD = 10'h2, MAP_WR = 10'h1;
  logic        clk, rst_n, moveWrite, clearAcc, moveSampleEn;
  logic        loadOperandOp, multiplyOp, unsignedMultiplyOp;
  logic        multiplyAccumulateOp, repeatClearOp, auxLoad, ptrLoad;
  logic        indirectEn, indexLoad, auxMapWrite;
  logic [1:0]  opbSel, productShiftMode, auxLoadSrc;
  logic [2:0]  auxLoadSel, auxAdjust, auxPointer;
  logic [3:0]  auxMapAddr;
  logic [15:0] dataBus, immShort, immLong, auxImm, pc, progBus;
  logic [15:0] operandOut, dataAddr, moveAddr, auxOut, auxMapData, indexOut;
  logic [31:0] accIn, productOut, shiftedProduct;
  int          n_errors = 0;
  int          compares = 0;

  always #5 clk = ~clk;
  coef_rom u_rom (.addr(pc), .coef(progBus));
  mult_aux_datapath u_dut (.*);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // strobes set together so each changes once per falling edge
  task automatic cyc(input logic [9:0] s);
    {loadOperandOp, multiplyOp, unsignedMultiplyOp, multiplyAccumulateOp,
     repeatClearOp, auxLoad, ptrLoad, indirectEn, indexLoad, auxMapWrite} = s;
    @(negedge clk);
  endtask

  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic t_mult;
    logic [31:0] sh [4];
    sh = '{32'hc0017ffe, 32'h8002fffc, 32'h0017ffe0, 32'hff0005ff};
    dataBus = 16'h8001;
    cyc(LOAD_OP);
    chk(32'(operandOut), 32'h8001);
    dataBus = 16'h7ffe;
    cyc(MUL_OP);
    chk(productOut, 32'hc0017ffe);
    for (int m = 0; m < 4; m++) begin
      productShiftMode = m[1:0];
      cyc(10'h0);
      chk(shiftedProduct, sh[m]);
    end
    cyc(UMUL_OP);
    chk(productOut, 32'h3fff7ffe);
    $display("mult test done");
  endtask

  task automatic t_imm;
    immShort = 16'h0003;
    opbSel = 2'h1;
    cyc(MUL_OP);
    chk(productOut, 32'hfffe8003);
    immLong = 16'hfffe;
    opbSel = 2'h2;
    cyc(MUL_OP);
    chk(productOut, 32'h0000fffe);
    opbSel = 2'h0;
    $display("immediate test done");
  endtask

  task automatic t_aux;
    logic [2:0]  adj [5];
    logic [15:0] adr [5];
    adj = '{3'h1, 3'h3, 3'h4, 3'h2, 3'h0};
    adr = '{16'h0200, 16'h0201, 16'h0211, 16'h0201, 16'h0200};
    auxImm = 16'h0200;
    auxLoadSrc = 2'h3;
    auxLoadSel = 3'h3;
    cyc(AUX_LD);
    auxImm = 16'h0003;
    dataBus = 16'h0010;
    cyc(PTR_LD | IDX_LD);
    chk(32'(auxPointer), 32'h3);
    chk(32'(indexOut), 32'h0010);
    for (int k = 0; k < 5; k++) begin
      auxAdjust = adj[k];
      cyc(IND_OP);
      chk(32'(dataAddr), 32'(adr[k]));
    end
    chk(32'(auxOut), 32'h0200);
    auxMapAddr = 4'h3;
    dataBus = 16'h1234;
    cyc(MAP_WR);
    // top address bit set: write must be dropped
    auxMapAddr = 4'hb;
    dataBus = 16'h5555;
    cyc(MAP_WR);
    auxMapAddr = 4'h3;
    cyc(10'h0);
    chk(32'(auxMapData), 32'h1234);
    accIn = 32'h0007_0200;
    auxLoadSrc = 2'h1;
    cyc(AUX_LD);
    chk(32'(auxOut), 32'h0200);
    $display("aux test done");
  endtask

  task automatic t_accum;
    logic [15:0]        c;
    logic signed [31:0] p;
    cyc(CLR_OP);
    chk(productOut, 32'h0);
    chk(32'(clearAcc), 32'h1);
    auxAdjust = 3'h1;
    moveSampleEn = 1'b1;
    for (int i = 0; i < 3; i++) begin
      pc = 16'h0010 + 16'(i);
      dataBus = 16'h9000 + 16'(i);
      c = {pc[7:0] ^ 8'ha5, pc[7:0]};
      p = $signed(c) * $signed(dataBus);
      cyc(ACC_OP | IND_OP);
      chk(productOut, p);
      chk(32'(dataAddr), 32'h0200 + 32'(i));
      chk(32'(moveAddr), 32'h0201 + 32'(i));
      chk(32'(moveWrite), 32'h1);
    end
    moveSampleEn = 1'b0;
    cyc(10'h0);
    chk(32'(moveWrite), 32'h0);
    $display("accumulate test done");
  endtask

  initial begin
    {clk, rst_n, moveSampleEn, opbSel, productShiftMode, auxLoadSrc,
     auxLoadSel, auxAdjust, auxMapAddr, dataBus, immShort, immLong, auxImm,
     pc, accIn} = '0;
    repeat (20) cyc(10'h0);
    rst_n = 1'b1;
    t_mult;
    t_imm;
    t_aux;
    t_accum;
    end_of_test;
  end

  // whole run is under a hundred cycles after reset
  initial begin
    #5000;
    n_errors++;
    end_of_test;
  end
endmodule // multiplier_and_aux_address_unit_test
